// File: rtl/dtc_timer_regs.sv
// dtc_timer_regs: apb register file and control of the two timers
`timescale 1ns/100ps

// Behaviour
// - timer b rollover sets its flag unless timer a is split; vector clears
// - timer a rollover sets its flag; vector clears
// - timer b run bit starts and stops it unless timer a is split
// - ext irq a condition sets its flag
// - edge mode flag clears on service only
// - timer b source: prescaled clock or pin falls
// - mode field picks 13-bit, 16-bit, reload
// - timer a low reloads from high
// - timer a high byte resets to zero
// - gating needs run bit and pin high
// - split high byte uses timer b bits
// - timer b mode three holds count
// - timer b reload leaves high unchanged
module dtc_timer_regs (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic timer_a_count_pin_in,
	input wire logic timer_b_count_pin_in,
	input wire logic ext_irq_a_pin_n_in,
	input wire logic ext_irq_b_pin_n_in,
	input wire logic timer_a_vector_ack_in,
	input wire logic timer_b_vector_ack_in,
	input wire logic ext_irq_a_ack_in,
	input wire logic ext_irq_b_ack_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic irq_out
);

	// ******************************************************
	// declarations
	// ******************************************************
	dtc_pkg::dtc_apb_req_t req; // bundled bus request
	dtc_pkg::dtc_control_t ctrl_ff; // shared control register
	dtc_pkg::dtc_mode_t mode_ff; // mode control register
	logic [31:0] prdata_ff; // read data, latched at setup
	logic pready_ff; // access phase answer
	logic pslverr_ff; // unmapped address answer
	logic irq_ff; // level interrupt
	logic [3:0] irq_status_ff; // sticky events
	logic [3:0] irq_enable_ff; // event mask
	logic [2:0] presc_ff; // clock prescaler
	logic cnt_a_prev_ff; // count pin history
	logic cnt_b_prev_ff;
	logic ext_a_prev_ff; // irq pin history
	logic ext_b_prev_ff;
	logic [7:0] a_low, a_high, b_low, b_high;
	logic a_ovf, a_hi_ovf, b_ovf, b_ovf_unused;
	logic [7:0] rd_byte;
	logic rd_hit;
	logic setup, wr_en;
	logic wr_ctrl, wr_mode, wr_a_lo, wr_a_hi, wr_b_lo, wr_b_hi;
	logic wr_ien, wr_iclr;
	logic tick, a_split, a_inc, a_hi_inc, b_inc;
	logic ext_a_event, ext_b_event, b_flag_set;
	logic [1:0] a_mode, b_mode;
	logic [3:0] events;

	// word-aligned address decode for one register index
	function automatic logic reg_hit(input logic [11:0] addr,
		input logic [7:0] idx);
		return (addr[11:10] == 2'h0) && (addr[9:2] == idx) &&
			(addr[1:0] == 2'h0);
	endfunction : reg_hit

	// ******************************************************
	// apb slave: one-cycle access phase, answer from flops
	// ******************************************************
	assign req = '{psel_in, penable_in, pwrite_in, paddr_in, pwdata_in};
	assign setup = req.sel & ~req.enable;
	// writes land only on the edge that completes the access
	assign wr_en = req.sel & req.enable & req.write & pready_ff &
		~pslverr_ff;
	assign wr_ctrl = wr_en & reg_hit(req.addr, dtc_pkg::IDX_CONTROL);
	assign wr_mode = wr_en & reg_hit(req.addr, dtc_pkg::IDX_MODE);
	assign wr_a_lo = wr_en & reg_hit(req.addr, dtc_pkg::IDX_A_LOW);
	assign wr_a_hi = wr_en & reg_hit(req.addr, dtc_pkg::IDX_A_HIGH);
	assign wr_b_lo = wr_en & reg_hit(req.addr, dtc_pkg::IDX_B_LOW);
	assign wr_b_hi = wr_en & reg_hit(req.addr, dtc_pkg::IDX_B_HIGH);
	assign wr_ien = wr_en & reg_hit(req.addr, dtc_pkg::IDX_IRQ_ENABLE);
	assign wr_iclr = wr_en & reg_hit(req.addr, dtc_pkg::IDX_IRQ_CLEAR);

	// read mux; the clear register reads as zero
	always_comb
	begin
		rd_byte = 8'h00;
		rd_hit = 1'b1;
		if (reg_hit(req.addr, dtc_pkg::IDX_CONTROL))
			rd_byte = ctrl_ff;
		else if (reg_hit(req.addr, dtc_pkg::IDX_MODE))
			rd_byte = mode_ff;
		else if (reg_hit(req.addr, dtc_pkg::IDX_A_LOW))
			rd_byte = a_low;
		else if (reg_hit(req.addr, dtc_pkg::IDX_A_HIGH))
			rd_byte = a_high;
		else if (reg_hit(req.addr, dtc_pkg::IDX_B_LOW))
			rd_byte = b_low;
		else if (reg_hit(req.addr, dtc_pkg::IDX_B_HIGH))
			rd_byte = b_high;
		else if (reg_hit(req.addr, dtc_pkg::IDX_IRQ_STATUS))
			rd_byte = {4'h0, irq_status_ff};
		else if (reg_hit(req.addr, dtc_pkg::IDX_IRQ_ENABLE))
			rd_byte = {4'h0, irq_enable_ff};
		else if (!reg_hit(req.addr, dtc_pkg::IDX_IRQ_CLEAR))
			rd_hit = 1'b0;
	end

	// answer flops; read data is a snapshot taken at setup
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
		end
		else if (ce_in)
		begin
			pready_ff <= setup;
			pslverr_ff <= setup & ~rd_hit;
			if (setup)
				prdata_ff <= {24'h000000, rd_byte};
		end
	end

	// ******************************************************
	// pin history and prescaler
	// ******************************************************
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cnt_a_prev_ff <= 1'b1;
			cnt_b_prev_ff <= 1'b1;
			ext_a_prev_ff <= 1'b1;
			ext_b_prev_ff <= 1'b1;
		end
		else if (ce_in)
		begin
			cnt_a_prev_ff <= timer_a_count_pin_in;
			cnt_b_prev_ff <= timer_b_count_pin_in;
			ext_a_prev_ff <= ext_irq_a_pin_n_in;
			ext_b_prev_ff <= ext_irq_b_pin_n_in;
		end
	end

	// free-running divider shared by both timers
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			presc_ff <= 3'h0;
		else if (ce_in)
			presc_ff <= tick ? 3'h0 : presc_ff + 3'h1;
	end
	assign tick = (presc_ff == dtc_pkg::PRESCALE_LAST);

	// ******************************************************
	// count enables
	// ******************************************************
	assign a_mode = {mode_ff.timer_a_mode_hi, mode_ff.timer_a_mode_lo};
	assign b_mode = {mode_ff.timer_b_mode_hi, mode_ff.timer_b_mode_lo};
	assign a_split = (a_mode == dtc_pkg::MODE_SPLIT);
	// gate opens while the irq pin stands high
	assign a_inc = ctrl_ff.timer_a_run &
		(~mode_ff.timer_a_pin_gating | ext_irq_a_pin_n_in) &
		(mode_ff.timer_a_source_select ?
		dtc_pkg::fall_edge(cnt_a_prev_ff, timer_a_count_pin_in) : tick);
	// split high byte borrows timer b run and counts ticks only
	assign a_hi_inc = ctrl_ff.timer_b_run & tick;
	// with timer a split, timer b has no run bit and is stopped by mode
	assign b_inc = (a_split | ctrl_ff.timer_b_run) &
		(~mode_ff.timer_b_pin_gating | ext_irq_b_pin_n_in) &
		(mode_ff.timer_b_source_select ?
		dtc_pkg::fall_edge(cnt_b_prev_ff, timer_b_count_pin_in) : tick);

	dtc_timer_unit u_timer_a (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.inc_in(a_inc),
		.hi_inc_in(a_hi_inc),
		.split_en_in(1'b1),
		.wr_lo_in(wr_a_lo),
		.wr_hi_in(wr_a_hi),
		.mode_in(a_mode),
		.wdata_in(req.wdata[7:0]),
		.low_out(a_low),
		.high_out(a_high),
		.ovf_out(a_ovf),
		.hi_ovf_out(a_hi_ovf)
	);

	// split disabled: mode three on timer b is a hold
	dtc_timer_unit u_timer_b (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.inc_in(b_inc),
		.hi_inc_in(1'b0),
		.split_en_in(1'b0),
		.wr_lo_in(wr_b_lo),
		.wr_hi_in(wr_b_hi),
		.mode_in(b_mode),
		.wdata_in(req.wdata[7:0]),
		.low_out(b_low),
		.high_out(b_high),
		.ovf_out(b_ovf),
		.hi_ovf_out(b_ovf_unused)
	);

	// ******************************************************
	// control and mode registers
	// ******************************************************
	// low level or falling edge on the active-low pins
	assign ext_a_event = ctrl_ff.ext_irq_a_type ?
		dtc_pkg::fall_edge(ext_a_prev_ff, ext_irq_a_pin_n_in) :
		~ext_irq_a_pin_n_in;
	assign ext_b_event = ctrl_ff.ext_irq_b_type ?
		dtc_pkg::fall_edge(ext_b_prev_ff, ext_irq_b_pin_n_in) :
		~ext_irq_b_pin_n_in;
	assign b_flag_set = a_split ? a_hi_ovf : b_ovf;

	// flags: hardware set always wins over any clear
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			ctrl_ff <= dtc_pkg::RST_CONTROL;
		else if (ce_in)
		begin
			if (wr_ctrl)
				ctrl_ff <= req.wdata[7:0];
			else
			begin
				if (timer_b_vector_ack_in)
					ctrl_ff.timer_b_overflow_flag <= 1'b0;
				if (timer_a_vector_ack_in)
					ctrl_ff.timer_a_overflow_flag <= 1'b0;
				if (ext_irq_a_ack_in && ctrl_ff.ext_irq_a_type)
					ctrl_ff.ext_irq_a_flag <= 1'b0;
				if (ext_irq_b_ack_in && ctrl_ff.ext_irq_b_type)
					ctrl_ff.ext_irq_b_flag <= 1'b0;
			end
			if (b_flag_set)
				ctrl_ff.timer_b_overflow_flag <= 1'b1;
			if (a_ovf)
				ctrl_ff.timer_a_overflow_flag <= 1'b1;
			if (ext_a_event)
				ctrl_ff.ext_irq_a_flag <= 1'b1;
			if (ext_b_event)
				ctrl_ff.ext_irq_b_flag <= 1'b1;
		end
	end

	// mode register; change modes only with the timer stopped
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			mode_ff <= dtc_pkg::RST_MODE;
		else if (ce_in && wr_mode)
			mode_ff <= req.wdata[7:0];
	end

	// ******************************************************
	// interrupt status, enable and output
	// ******************************************************
	always_comb
	begin
		events = 4'h0;
		events[dtc_pkg::EV_TIMER_A] = a_ovf;
		events[dtc_pkg::EV_TIMER_B] = b_flag_set;
		events[dtc_pkg::EV_EXT_A] = ext_a_event;
		events[dtc_pkg::EV_EXT_B] = ext_b_event;
	end

	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			irq_status_ff <= dtc_pkg::RST_IRQ;
			irq_enable_ff <= dtc_pkg::RST_IRQ;
			irq_ff <= 1'b0;
		end
		else if (ce_in)
		begin
			irq_status_ff <= (irq_status_ff &
				~(wr_iclr ? req.wdata[3:0] : 4'h0)) | events;
			if (wr_ien)
				irq_enable_ff <= req.wdata[3:0];
			irq_ff <= |(irq_status_ff & irq_enable_ff);
		end
	end

	assign prdata_out = prdata_ff;
	assign pready_out = pready_ff;
	assign pslverr_out = pslverr_ff;
	assign irq_out = irq_ff;

	// ******************************************************
	// assertions
	// ******************************************************
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_setup;
		ce_in && psel_in && !penable_in;
	endsequence
	sequence s_access;
		ce_in && psel_in && penable_in;
	endsequence

	AST_APB_READY: assert property (s_setup ##1 s_access |-> pready_out)
		else $error("access phase without ready");
	AST_B_FLAG_SET: assert property (
		ce_in && b_flag_set |=> ctrl_ff.timer_b_overflow_flag)
		else $error("timer b overflow did not set its flag");
	AST_A_FLAG_SET: assert property (
		ce_in && a_ovf |=> ctrl_ff.timer_a_overflow_flag)
		else $error("timer a overflow did not set its flag");
	AST_B_STOPPED: assert property (
		ce_in && !a_split && !ctrl_ff.timer_b_run && !wr_b_lo
		|=> $stable(b_low))
		else $error("timer b counted while stopped");
	AST_EXT_A_SET: assert property (
		ce_in && ext_a_event |=> ctrl_ff.ext_irq_a_flag)
		else $error("ext irq a flag not set");
	AST_EXT_A_LEVEL: assert property (
		ce_in && !ctrl_ff.ext_irq_a_type && ctrl_ff.ext_irq_a_flag &&
		!wr_ctrl |=> ctrl_ff.ext_irq_a_flag)
		else $error("level mode flag cleared by hardware");
	AST_A_RELOAD: assert property (
		ce_in && a_mode == dtc_pkg::MODE_RELOAD && a_inc &&
		a_low == 8'hFF && !wr_a_lo && !wr_a_hi
		|=> a_low == $past(a_high) && $stable(a_high))
		else $error("timer a reload wrong");
	AST_B_HOLD: assert property (
		ce_in && b_mode == dtc_pkg::MODE_SPLIT && !wr_b_lo && !wr_b_hi
		|=> $stable({b_high, b_low}))
		else $error("timer b moved in hold mode");
	AST_A_GATED: assert property (
		ce_in && mode_ff.timer_a_pin_gating && !ext_irq_a_pin_n_in &&
		!wr_a_lo && !wr_a_hi |=> $stable(a_low))
		else $error("timer a counted with gate closed");
	AST_IRQ_LEVEL: assert property (
		ce_in ##1 ce_in |-> irq_out == $past(|(irq_status_ff & irq_enable_ff)))
		else $error("interrupt output mismatch");

endmodule : dtc_timer_regs

// File: rtl/dtc_pkg.sv
// dtc_pkg: constants, register layouts and helpers for the dual timer block
package dtc_pkg;

	// ******************************************************
	// register indices (byte address is four times the index)
	// ******************************************************
	localparam logic [7:0] IDX_CONTROL = 8'h88; // shared control
	localparam logic [7:0] IDX_MODE = 8'h89; // mode control
	localparam logic [7:0] IDX_A_LOW = 8'h8A; // timer a low byte
	localparam logic [7:0] IDX_B_LOW = 8'h8B; // timer b low byte
	localparam logic [7:0] IDX_A_HIGH = 8'h8C; // timer a high byte
	localparam logic [7:0] IDX_B_HIGH = 8'h8D; // timer b high byte
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h90; // sticky events, ro
	localparam logic [7:0] IDX_IRQ_ENABLE = 8'h91; // event enables
	localparam logic [7:0] IDX_IRQ_CLEAR = 8'h92; // write one to clear

	// ******************************************************
	// reset values
	// ******************************************************
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [3:0] RST_IRQ = 4'h0;

	// ******************************************************
	// operating modes and timing
	// ******************************************************
	localparam logic [1:0] MODE_13BIT = 2'h0; // high byte, 5-bit prescale
	localparam logic [1:0] MODE_16BIT = 2'h1; // cascaded bytes
	localparam logic [1:0] MODE_RELOAD = 2'h2; // 8-bit auto-reload
	localparam logic [1:0] MODE_SPLIT = 2'h3; // split for a, halt for b
	localparam logic [4:0] LOW_PRESCALE_MAX = 5'h1F; // modulo-32 top
	localparam logic [2:0] PRESCALE_DIV = 3'h6; // clocks per timer tick
	localparam logic [2:0] PRESCALE_LAST = PRESCALE_DIV - 3'h1;

	// ******************************************************
	// interrupt event bit positions
	// ******************************************************
	localparam int EV_TIMER_A = 0;
	localparam int EV_TIMER_B = 1;
	localparam int EV_EXT_A = 2;
	localparam int EV_EXT_B = 3;

	// shared control register layout, msb first
	typedef struct packed {
		logic timer_b_overflow_flag;
		logic timer_b_run;
		logic timer_a_overflow_flag;
		logic timer_a_run;
		logic ext_irq_b_flag;
		logic ext_irq_b_type;
		logic ext_irq_a_flag;
		logic ext_irq_a_type;
	} dtc_control_t;

	// mode control register layout, msb first
	typedef struct packed {
		logic timer_b_pin_gating;
		logic timer_b_source_select;
		logic timer_b_mode_hi;
		logic timer_b_mode_lo;
		logic timer_a_pin_gating;
		logic timer_a_source_select;
		logic timer_a_mode_hi;
		logic timer_a_mode_lo;
	} dtc_mode_t;

	// one apb request as the master presents it
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} dtc_apb_req_t;

	// falling edge between a stored sample and the present level
	function automatic logic fall_edge(input logic prev, input logic cur);
		return prev & ~cur;
	endfunction : fall_edge

endpackage : dtc_pkg

// File: rtl/dtc_timer_unit.sv
// dtc_timer_unit: one timer's low and high count bytes with mode logic
`timescale 1ns/100ps

module dtc_timer_unit (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic inc_in,
	input wire logic hi_inc_in,
	input wire logic split_en_in,
	input wire logic wr_lo_in,
	input wire logic wr_hi_in,
	input wire logic [1:0] mode_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] low_out,
	output logic [7:0] high_out,
	output logic ovf_out,
	output logic hi_ovf_out
);

	logic [7:0] low_ff; // low count byte
	logic [7:0] high_ff; // high count byte
	logic [7:0] nxt_low;
	logic [7:0] nxt_high;

	// ******************************************************
	// next count and overflow events
	// ******************************************************
	always_comb
	begin
		nxt_low = low_ff;
		nxt_high = high_ff;
		ovf_out = 1'b0;
		hi_ovf_out = 1'b0;
		if (inc_in)
		begin
			case (mode_in)
				dtc_pkg::MODE_13BIT:
				begin
					// upper three low bits are left alone
					nxt_low[4:0] = low_ff[4:0] + 5'h01;
					if (low_ff[4:0] == dtc_pkg::LOW_PRESCALE_MAX)
					begin
						nxt_high = high_ff + 8'h01;
						ovf_out = (high_ff == 8'hFF);
					end
				end
				dtc_pkg::MODE_16BIT:
				begin
					{nxt_high, nxt_low} = {high_ff, low_ff} + 16'h0001;
					ovf_out = &{high_ff, low_ff};
				end
				dtc_pkg::MODE_RELOAD:
				begin
					// reload copies high into low and never touches high
					if (low_ff == 8'hFF)
					begin
						nxt_low = high_ff;
						ovf_out = 1'b1;
					end
					else
						nxt_low = low_ff + 8'h01;
				end
				default:
				begin
					// split keeps low running; otherwise the count holds
					if (split_en_in)
					begin
						nxt_low = low_ff + 8'h01;
						ovf_out = &low_ff;
					end
				end
			endcase
		end
		// separate high byte count while split
		if (split_en_in && mode_in == dtc_pkg::MODE_SPLIT && hi_inc_in)
		begin
			nxt_high = high_ff + 8'h01;
			hi_ovf_out = &high_ff;
		end
		// a software write beats counting in the same cycle
		if (wr_lo_in)
			nxt_low = wdata_in;
		if (wr_hi_in)
			nxt_high = wdata_in;
	end

	// ******************************************************
	// count registers
	// ******************************************************
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			low_ff <= dtc_pkg::RST_COUNT;
			high_ff <= dtc_pkg::RST_COUNT;
		end
		else if (ce_in)
		begin
			low_ff <= nxt_low;
			high_ff <= nxt_high;
		end
	end

	assign low_out = low_ff;
	assign high_out = high_ff;

endmodule : dtc_timer_unit

// File: verification/dtc_timer_regs_tb_top.sv
// dtc_timer_regs_tb_top: self-checking testbench for the dual timer registers
`timescale 1ns/100ps

module dtc_timer_regs_tb_top;

	// ******************************************************
	// stimulus and response signals
	// ******************************************************
	logic clk; // 20 MHz core clock
	logic rst; // async reset, active high
	logic psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic pin_a, pin_b; // count pins, idle high
	logic ext_a_n, ext_b_n; // active-low external irq pins
	logic vec_a, vec_b, ack_a, ack_b; // service pulses
	logic [31:0] prdata;
	logic pready, pslverr, irq;
	int n_mismatch = 0;
	int checked = 0;
	logic [7:0] rv; // last read byte
	logic er; // last error response

	dtc_timer_regs dut (
		.core_clk_in(clk), .rst_in(rst), .ce_in(1'b1),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata),
		.timer_a_count_pin_in(pin_a), .timer_b_count_pin_in(pin_b),
		.ext_irq_a_pin_n_in(ext_a_n), .ext_irq_b_pin_n_in(ext_b_n),
		.timer_a_vector_ack_in(vec_a), .timer_b_vector_ack_in(vec_b),
		.ext_irq_a_ack_in(ack_a), .ext_irq_b_ack_in(ack_b),
		.prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .irq_out(irq)
	);

	// free running clock, 50 ns period
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ******************************************************
	// shared tasks
	// ******************************************************

	// verdict and the single exit point of the run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	// compare one byte, four-state exact
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", what, exp, got);
			n_mismatch++;
		end
	endtask : chk

	// one apb transfer; entered just after a rising edge, leaves one
	// idle cycle so a following call never re-drives psel in one step
	task automatic apb(input logic wr, input logic [7:0] idx,
		input logic [7:0] wd);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h0, wd};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rv = prdata[7:0];
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (n >= 20)
		begin
			// a hung slave ends the run here
			n_mismatch++;
			end_of_test();
		end
	endtask : apb

	// read a register and compare data and error response
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
		input logic exp_err);
		apb(1'b0, idx, 8'h00);
		chk($sformatf("reg %h", idx), exp, rv);
		chk("pslverr", {7'h0, exp_err}, {7'h0, er});
	endtask : rd

	// poll a register bit under a bounded count
	task automatic poll(input logic [7:0] idx, input int b);
		int n;
		n = 0;
		do
		begin
			apb(1'b0, idx, 8'h00);
			n++;
		end
		while (rv[b] !== 1'b1 && n < 40);
		chk("poll bit", 8'h01, {7'h0, rv[b]});
		// a bit that never came counts once and ends the run
		if (rv[b] !== 1'b1)
			end_of_test();
	endtask : poll

	// one-cycle pulse: 0 vector a, 1 vector b, 2 ack a, 3 ack b
	task automatic pulse(input int w);
		vec_a <= (w == 0);
		vec_b <= (w == 1);
		ack_a <= (w == 2);
		ack_b <= (w == 3);
		@(posedge clk);
		vec_a <= 1'b0;
		vec_b <= 1'b0;
		ack_a <= 1'b0;
		ack_b <= 1'b0;
		@(posedge clk);
	endtask : pulse

	// ******************************************************
	// scenarios
	// ******************************************************

	// reset values and an unmapped access
	task automatic sc_reset();
		rd(dtc_pkg::IDX_CONTROL, 8'h00, 1'b0);
		rd(dtc_pkg::IDX_MODE, 8'h00, 1'b0);
		rd(dtc_pkg::IDX_A_LOW, 8'h00, 1'b0);
		rd(dtc_pkg::IDX_A_HIGH, 8'h00, 1'b0);
		rd(8'h87, 8'h00, 1'b1);
	endtask : sc_reset

	// timer a 8-bit reload from high, flag, vector clear
	task automatic sc_a_reload();
		apb(1'b1, dtc_pkg::IDX_A_HIGH, 8'hF0);
		apb(1'b1, dtc_pkg::IDX_A_LOW, 8'hFE);
		apb(1'b1, dtc_pkg::IDX_MODE, 8'h02);
		apb(1'b1, dtc_pkg::IDX_CONTROL, 8'h10);
		poll(dtc_pkg::IDX_CONTROL, 5);
		pulse(0);
		rd(dtc_pkg::IDX_CONTROL, 8'h10, 1'b0);
		apb(1'b1, dtc_pkg::IDX_CONTROL, 8'h00);
		rd(dtc_pkg::IDX_A_HIGH, 8'hF0, 1'b0);
		apb(1'b0, dtc_pkg::IDX_A_LOW, 8'h00);
		checked++;
		// low byte must have restarted from the high byte; x fails too
		if ((rv >= 8'hF0 && rv <= 8'hF3) !== 1'b1)
		begin
			$display("Error reload low byte expected f0..f3 seen %h", rv);
			n_mismatch++;
		end
	endtask : sc_a_reload

	// timer b 16-bit counter on pin falls, rollover flag
	task automatic sc_b_counter();
		apb(1'b1, dtc_pkg::IDX_MODE, 8'h50);
		apb(1'b1, dtc_pkg::IDX_B_LOW, 8'hFF);
		apb(1'b1, dtc_pkg::IDX_B_HIGH, 8'hFF);
		apb(1'b1, dtc_pkg::IDX_CONTROL, 8'h40);
		repeat (14) @(posedge clk);
		rd(dtc_pkg::IDX_B_LOW, 8'hFF, 1'b0);
		pin_b <= 1'b0;
		@(posedge clk);
		pin_b <= 1'b1;
		@(posedge clk);
		rd(dtc_pkg::IDX_CONTROL, 8'hC0, 1'b0);
		rd(dtc_pkg::IDX_B_LOW, 8'h00, 1'b0);
		rd(dtc_pkg::IDX_B_HIGH, 8'h00, 1'b0);
		pulse(1);
		rd(dtc_pkg::IDX_CONTROL, 8'h40, 1'b0);
	endtask : sc_b_counter

	// timer b mode three holds its count while run is set
	task automatic sc_b_hold();
		apb(1'b1, dtc_pkg::IDX_MODE, 8'h30);
		apb(1'b1, dtc_pkg::IDX_B_LOW, 8'h12);
		repeat (30) @(posedge clk);
		rd(dtc_pkg::IDX_B_LOW, 8'h12, 1'b0);
		apb(1'b1, dtc_pkg::IDX_CONTROL, 8'h00);
	endtask : sc_b_hold

	// timer a gated by the external pin level
	task automatic sc_gate();
		apb(1'b1, dtc_pkg::IDX_MODE, 8'h09);
		apb(1'b1, dtc_pkg::IDX_A_LOW, 8'h00);
		ext_a_n <= 1'b0;
		apb(1'b1, dtc_pkg::IDX_CONTROL, 8'h11);
		repeat (24) @(posedge clk);
		rd(dtc_pkg::IDX_A_LOW, 8'h00, 1'b0);
		ext_a_n <= 1'b1;
		repeat (24) @(posedge clk);
		apb(1'b0, dtc_pkg::IDX_A_LOW, 8'h00);
		chk("gate open counts", 8'h01, {7'h0, rv > 8'h02});
		apb(1'b1, dtc_pkg::IDX_CONTROL, 8'h00);
	endtask : sc_gate

	// external irq a: edge flag cleared by service, level flag kept
	task automatic sc_ext();
		apb(1'b1, dtc_pkg::IDX_CONTROL, 8'h01);
		ext_a_n <= 1'b0;
		@(posedge clk);
		@(posedge clk);
		rd(dtc_pkg::IDX_CONTROL, 8'h03, 1'b0);
		pulse(2);
		rd(dtc_pkg::IDX_CONTROL, 8'h01, 1'b0);
		apb(1'b1, dtc_pkg::IDX_CONTROL, 8'h00);
		pulse(2);
		rd(dtc_pkg::IDX_CONTROL, 8'h02, 1'b0);
		ext_a_n <= 1'b1;
		@(posedge clk);
		apb(1'b1, dtc_pkg::IDX_CONTROL, 8'h00);
		rd(dtc_pkg::IDX_CONTROL, 8'h00, 1'b0);
		// pin b low in level mode: flag set, service leaves it
		ext_b_n <= 1'b0;
		@(posedge clk);
		@(posedge clk);
		pulse(3);
		rd(dtc_pkg::IDX_CONTROL, 8'h08, 1'b0);
		ext_b_n <= 1'b1;
		@(posedge clk);
		apb(1'b1, dtc_pkg::IDX_CONTROL, 8'h00);
	endtask : sc_ext

	// timer a split: high byte borrows b run and b flag; b in 13-bit
	task automatic sc_split();
		apb(1'b1, dtc_pkg::IDX_MODE, 8'h03);
		apb(1'b1, dtc_pkg::IDX_A_LOW, 8'h00);
		apb(1'b1, dtc_pkg::IDX_A_HIGH, 8'hFE);
		apb(1'b1, dtc_pkg::IDX_B_LOW, 8'hE0);
		apb(1'b1, dtc_pkg::IDX_CONTROL, 8'h40);
		poll(dtc_pkg::IDX_CONTROL, 7);
		rd(dtc_pkg::IDX_A_LOW, 8'h00, 1'b0);
		apb(1'b0, dtc_pkg::IDX_B_LOW, 8'h00);
		chk("b low top bits", 8'hE0, rv & 8'hE0);
		apb(1'b1, dtc_pkg::IDX_CONTROL, 8'h00);
		apb(1'b1, dtc_pkg::IDX_MODE, 8'h00);
	endtask : sc_split

	// interrupt output: raise, mask, clear, read-only status
	task automatic sc_irq();
		apb(1'b1, dtc_pkg::IDX_IRQ_ENABLE, 8'h04);
		@(posedge clk);
		chk("irq raised", 8'h01, {7'h0, irq});
		apb(1'b1, dtc_pkg::IDX_IRQ_ENABLE, 8'h00);
		@(posedge clk);
		chk("irq masked", 8'h00, {7'h0, irq});
		apb(1'b1, dtc_pkg::IDX_IRQ_STATUS, 8'h00);
		apb(1'b0, dtc_pkg::IDX_IRQ_STATUS, 8'h00);
		chk("status kept", 8'h04, rv & 8'h04);
		apb(1'b1, dtc_pkg::IDX_IRQ_CLEAR, 8'h0F);
		rd(dtc_pkg::IDX_IRQ_STATUS, 8'h00, 1'b0);
		rd(dtc_pkg::IDX_IRQ_CLEAR, 8'h00, 1'b0);
	endtask : sc_irq

	// ******************************************************
	// main sequence
	// ******************************************************
	initial
	begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pin_a = 1'b1;
		pin_b = 1'b1;
		ext_a_n = 1'b1;
		ext_b_n = 1'b1;
		vec_a = 1'b0;
		vec_b = 1'b0;
		ack_a = 1'b0;
		ack_b = 1'b0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		sc_reset();
		sc_a_reload();
		sc_b_counter();
		sc_b_hold();
		sc_gate();
		sc_ext();
		sc_split();
		sc_irq();
		end_of_test();
	end

endmodule : dtc_timer_regs_tb_top
